// *** hw/iac_map.svh ***
// offsets, field positions, reset values and timing figures of the
// interrupt acknowledge control; included by the design files
`ifndef IAC_MAP_SVH
`define IAC_MAP_SVH

// register indices, byte address is four times the index
`define IAC_IDX_IF_LOW   16'hFFE0
`define IAC_IDX_IF_HIGH  16'hFFE1
`define IAC_IDX_PSW      16'hFFE2
`define IAC_IDX_MK_LOW   16'hFFE4
`define IAC_IDX_MK_HIGH  16'hFFE5
`define IAC_IDX_EVT_STAT 16'hFFE6
`define IAC_IDX_EVT_MASK 16'hFFE7

// reset values
`define IAC_IF_RST       8'h00
`define IAC_MK_RST       8'hFF
`define IAC_PSW_RST      8'h02
`define IAC_EVT_RST      2'h0

// field positions
`define IAC_PSW_IE_BIT   7
`define IAC_EVT_ACK_BIT  0
`define IAC_EVT_NMI_BIT  1

// vector table entries
`define IAC_VEC_NMI      16'h0004
`define IAC_VEC_BASE     16'h0006

// request to service delay window, cpu clocks
`define IAC_LAT_MIN_CLK  9
`define IAC_LAT_MAX_CLK  19

`endif

// *** hw/iac_pkg.sv ***
// types shared by the interrupt acknowledge control files
// assumes nothing of its surroundings
package iac_pkg;

  typedef enum logic [1:0] {
    IAC_IDLE     = 2'b00,
    IAC_SAVE_PSW = 2'b01,
    IAC_SAVE_PC  = 2'b10,
    IAC_LOAD_PC  = 2'b11
  } iac_state_t;

  typedef logic [8:0] iac_src_t;

endpackage

// *** hw/iac_arbiter.sv ***
// fixed priority pick among pending requests, with vector lookup
// assumes flags and masks come from registers of the caller
`timescale 1ns/1ps
`default_nettype none
`include "iac_map.svh"

module iac_arbiter #(
  parameter int NSRC = 9
) (
  // pending state
  input  wire logic [NSRC-1:0] req_flags,
  input  wire logic [NSRC-1:0] mask_flags,
  input  wire logic            ie,
  input  wire logic            nmi_pend,
  // selection
  output logic                 hit,
  output logic                 is_nmi,
  output logic [3:0]           src_idx,
  output logic [15:0]          vector
);
  import iac_pkg::*;

  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    vec_of = `IAC_VEC_BASE + {11'h000, idx, 1'b0};
  endfunction

  always_comb begin
    logic [NSRC-1:0] elig;
    elig    = '0;
    hit     = 1'b0;
    is_nmi  = 1'b0;
    src_idx = 4'h0;
    vector  = 16'h0000;
    elig    = req_flags & ~mask_flags;
    // lowest index wins among maskable sources
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (elig[i] && ie) begin
        hit     = 1'b1;
        src_idx = 4'(i);
        vector  = vec_of(4'(i));
      end
    end
    // non-maskable ignores ie and beats all
    if (nmi_pend) begin
      hit     = 1'b1;
      is_nmi  = 1'b1;
      src_idx = 4'h0;
      vector  = `IAC_VEC_NMI;
    end
  end

endmodule
`default_nettype wire

// *** hw/iac_ctrl.sv ***
// interrupt acknowledge control: flags, masks, status word, acceptance
// assumes an apb master and a cpu sequencer on the same clock
//
// Notes on behaviour
// - non-maskable accepted always, ahead of maskable
// - nmi: push status, push pc, clear enable
// - new nmi interrupts running nmi service
// - maskable needs flag set, mask clear, enable
// - request to service takes 9 to 19 clocks
// - bit-test branches give the longest delay
// - simultaneous maskable requests taken by priority
// - unaccepted requests stay pending until acceptable
// - maskable: push status, pc, clear enable, vector
// - flag seen before clock n-1 accepted at end
// - flag set in last clock waits one instruction
// - flag or mask register access holds requests
// - flag or mask instruction defers one instruction
// - nesting only after enable instruction in service
// - without re-enable new request waits for return
// - accepted source flag cleared before service starts
// - return instruction restores status word from stack
`timescale 1ns/1ps
`default_nettype none
`include "iac_map.svh"

module iac_ctrl #(
  parameter int NSRC = 9
) (
  // clock and reset
  input  wire logic             CLOCK,
  input  wire logic             ARST_N,
  // apb slave
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [17:0]      PADDR,
  input  wire logic [31:0]      PWDATA,
  output logic                  PREADY,
  output logic [31:0]           PRDATA,
  output logic                  PSLVERR,
  // request sources
  input  wire iac_pkg::iac_src_t SRC_REQ,
  input  wire logic             NMI_REQ,
  // cpu sequencer
  input  wire logic             INSTR_LAST,
  input  wire logic             INSTR_HOLDS,
  input  wire logic             EI_EXEC,
  input  wire logic             DI_EXEC,
  input  wire logic             SERVICE_RETURN_INSTR_EXEC,
  input  wire logic [7:0]       SERVICE_RETURN_INSTR_PSW,
  input  wire logic [15:0]      CORE_PC,
  // acceptance sequence
  output logic                  ACK_BUSY,
  output logic                  STACK_WR,
  output logic                  STACK_SEL_PC,
  output logic [15:0]           STACK_DATA,
  output logic                  PC_LOAD,
  output logic [15:0]           PC_VECTOR,
  output logic                  GLOBAL_ACCEPT_ENABLE,
  // interrupt out
  output logic                  IRQ
);
  import iac_pkg::*;

  function automatic logic [17:0] addr_of(input logic [15:0] idx);
    addr_of = {idx, 2'b00};
  endfunction

  // reset release through two flops
  logic rst_meta_ff;
  logic rst_n;
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  iac_state_t        state_ff;
  iac_state_t        nxt_state;
  logic [NSRC-1:0]   if_ff;
  logic [NSRC-1:0]   mk_ff;
  logic [7:0]        psw_ff;
  logic              nmi_pend_ff;
  logic [1:0]        evt_ff;
  logic [1:0]        evt_mask_ff;
  logic              arm_hit_ff;
  logic              arm_nmi_ff;
  logic [3:0]        arm_idx_ff;
  logic [15:0]       arm_vec_ff;
  logic              sel_nmi_ff;
  logic [3:0]        sel_idx_ff;
  logic [15:0]       sel_vec_ff;
  logic              arb_hit;
  logic              arb_nmi;
  logic [3:0]        arb_idx;
  logic [15:0]       arb_vec;
  logic              start;
  logic              flag_access;
  logic              wr_en;
  logic [7:0]        wbyte;
  logic [NSRC-1:0]   nxt_if;
  logic [1:0]        nxt_evt;

  // flag and mask register packing
  function automatic logic [7:0] pack_if(input logic [NSRC-1:0] v, input logic hi);
    pack_if = hi ? {v[8], 6'h00, v[7]} : {1'b0, v[6:0]};
  endfunction

  function automatic logic [7:0] pack_mk(input logic [NSRC-1:0] v, input logic hi);
    pack_mk = hi ? {v[8], 6'h3F, v[7]} : {1'b1, v[6:0]};
  endfunction

  assign wr_en = PSEL && PENABLE && PREADY && PWRITE;
  assign wbyte = PWDATA[7:0];

  // accesses to flag or mask registers hold acceptance
  assign flag_access = PSEL && (PADDR == addr_of(`IAC_IDX_IF_LOW)
                             || PADDR == addr_of(`IAC_IDX_IF_HIGH)
                             || PADDR == addr_of(`IAC_IDX_MK_LOW)
                             || PADDR == addr_of(`IAC_IDX_MK_HIGH));

  iac_arbiter #(
    .NSRC (NSRC)
  ) u_arb (
    .req_flags  (if_ff),
    .mask_flags (mk_ff),
    .ie         (psw_ff[`IAC_PSW_IE_BIT]),
    .nmi_pend   (nmi_pend_ff),
    .hit        (arb_hit),
    .is_nmi     (arb_nmi),
    .src_idx    (arb_idx),
    .vector     (arb_vec)
  );

  // candidate sampled one clock ahead of the boundary
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      arm_hit_ff <= 1'b0;
      arm_nmi_ff <= 1'b0;
      arm_idx_ff <= 4'h0;
      arm_vec_ff <= 16'h0000;
    end else begin
      arm_hit_ff <= arb_hit;
      arm_nmi_ff <= arb_nmi;
      arm_idx_ff <= arb_idx;
      arm_vec_ff <= arb_vec;
    end
  end

  // accept only at an instruction end
  assign start = (state_ff == IAC_IDLE) && INSTR_LAST && arm_hit_ff
              && !INSTR_HOLDS && !flag_access;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      IAC_IDLE:     if (start) nxt_state = IAC_SAVE_PSW;
      IAC_SAVE_PSW: nxt_state = IAC_SAVE_PC;
      IAC_SAVE_PC:  nxt_state = IAC_LOAD_PC;
      IAC_LOAD_PC:  nxt_state = IAC_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= IAC_IDLE;
      sel_nmi_ff <= 1'b0;
      sel_idx_ff <= 4'h0;
      sel_vec_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      if (start) begin
        sel_nmi_ff <= arm_nmi_ff;
        sel_idx_ff <= arm_idx_ff;
        sel_vec_ff <= arm_vec_ff;
      end
    end
  end

  // stack and vector outputs, status word first then pc
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ACK_BUSY     <= 1'b0;
      STACK_WR     <= 1'b0;
      STACK_SEL_PC <= 1'b0;
      STACK_DATA   <= 16'h0000;
      PC_LOAD      <= 1'b0;
      PC_VECTOR    <= 16'h0000;
    end else begin
      ACK_BUSY     <= nxt_state != IAC_IDLE;
      STACK_WR     <= nxt_state == IAC_SAVE_PSW || nxt_state == IAC_SAVE_PC;
      STACK_SEL_PC <= nxt_state == IAC_SAVE_PC;
      PC_LOAD      <= nxt_state == IAC_LOAD_PC;
      if (start) begin
        STACK_DATA <= {8'h00, psw_ff};
      end else if (nxt_state == IAC_SAVE_PC) begin
        STACK_DATA <= CORE_PC;
      end
      if (nxt_state == IAC_LOAD_PC) begin
        PC_VECTOR <= sel_vec_ff;
      end
    end
  end

  // status word: acceptance clears enable
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      psw_ff <= `IAC_PSW_RST;
    end else if (start) begin
      psw_ff[`IAC_PSW_IE_BIT] <= 1'b0;
    end else if (SERVICE_RETURN_INSTR_EXEC) begin
      psw_ff <= SERVICE_RETURN_INSTR_PSW;
    end else if (EI_EXEC) begin
      psw_ff[`IAC_PSW_IE_BIT] <= 1'b1;
    end else if (DI_EXEC) begin
      psw_ff[`IAC_PSW_IE_BIT] <= 1'b0;
    end else if (wr_en && PADDR == addr_of(`IAC_IDX_PSW)) begin
      psw_ff <= wbyte;
    end
  end

  // request flags: cleared on acceptance, new request wins
  always_comb begin
    nxt_if = if_ff;
    if (wr_en && PADDR == addr_of(`IAC_IDX_IF_LOW)) begin
      nxt_if[6:0] = wbyte[6:0];
    end
    if (wr_en && PADDR == addr_of(`IAC_IDX_IF_HIGH)) begin
      nxt_if[7] = wbyte[0];
      nxt_if[8] = wbyte[7];
    end
    if (start && !arm_nmi_ff) begin
      nxt_if[arm_idx_ff] = 1'b0;
    end
    nxt_if = nxt_if | SRC_REQ;
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      if_ff <= '0;
    end else begin
      if_ff <= nxt_if;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      mk_ff <= '1;
    end else begin
      if (wr_en && PADDR == addr_of(`IAC_IDX_MK_LOW)) begin
        mk_ff[6:0] <= wbyte[6:0];
      end
      if (wr_en && PADDR == addr_of(`IAC_IDX_MK_HIGH)) begin
        mk_ff[7] <= wbyte[0];
        mk_ff[8] <= wbyte[7];
      end
    end
  end

  // non-maskable pending, also during its own service
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      nmi_pend_ff <= 1'b0;
    end else if (NMI_REQ) begin
      nmi_pend_ff <= 1'b1;
    end else if (start && arm_nmi_ff) begin
      nmi_pend_ff <= 1'b0;
    end
  end

  // event status, write one to clear, set wins
  always_comb begin
    nxt_evt = evt_ff;
    if (wr_en && PADDR == addr_of(`IAC_IDX_EVT_STAT)) begin
      nxt_evt = nxt_evt & ~wbyte[1:0];
    end
    if (start) begin
      nxt_evt[`IAC_EVT_ACK_BIT] = nxt_evt[`IAC_EVT_ACK_BIT] | !arm_nmi_ff;
      nxt_evt[`IAC_EVT_NMI_BIT] = nxt_evt[`IAC_EVT_NMI_BIT] | arm_nmi_ff;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      evt_ff      <= `IAC_EVT_RST;
      evt_mask_ff <= `IAC_EVT_RST;
      IRQ         <= 1'b0;
    end else begin
      evt_ff <= nxt_evt;
      if (wr_en && PADDR == addr_of(`IAC_IDX_EVT_MASK)) begin
        evt_mask_ff <= wbyte[1:0];
      end
      IRQ <= |(nxt_evt & evt_mask_ff);
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      GLOBAL_ACCEPT_ENABLE <= 1'b0;
    end else begin
      GLOBAL_ACCEPT_ENABLE <= psw_ff[`IAC_PSW_IE_BIT];
    end
  end

  // apb slave, one wait state
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      if (PSEL && PENABLE && !PREADY) begin
        unique case (PADDR)
          addr_of(`IAC_IDX_IF_LOW):   PRDATA[7:0] <= pack_if(if_ff, 1'b0);
          addr_of(`IAC_IDX_IF_HIGH):  PRDATA[7:0] <= pack_if(if_ff, 1'b1);
          addr_of(`IAC_IDX_MK_LOW):   PRDATA[7:0] <= pack_mk(mk_ff, 1'b0);
          addr_of(`IAC_IDX_MK_HIGH):  PRDATA[7:0] <= pack_mk(mk_ff, 1'b1);
          addr_of(`IAC_IDX_PSW):      PRDATA[7:0] <= psw_ff;
          addr_of(`IAC_IDX_EVT_STAT): PRDATA[1:0] <= evt_ff;
          addr_of(`IAC_IDX_EVT_MASK): PRDATA[1:0] <= evt_mask_ff;
          default:                    PSLVERR     <= 1'b1;
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n);

  logic [NSRC-1:0] elig_v;
  assign elig_v = if_ff & ~mk_ff;

  sequence s_push_psw;
    STACK_WR && !STACK_SEL_PC && ACK_BUSY;
  endsequence

  sequence s_push_pc_load;
    STACK_WR && STACK_SEL_PC ##1 PC_LOAD && !STACK_WR ##1 !ACK_BUSY;
  endsequence

  a_nmi_first: assert property (
    start && arm_nmi_ff |=> sel_nmi_ff && !PC_LOAD ##2
      PC_LOAD && PC_VECTOR == `IAC_VEC_NMI)
    else $error("nmi not taken first");

  a_save_order: assert property (
    $rose(ACK_BUSY) |-> s_push_psw ##1 s_push_pc_load)
    else $error("save sequence out of order");

  a_enable_clear: assert property (
    $rose(ACK_BUSY) |-> !psw_ff[`IAC_PSW_IE_BIT] && STACK_DATA[7:0] == $past(psw_ff))
    else $error("enable not cleared or wrong status pushed");

  a_mask_gate: assert property (
    arm_hit_ff && !arm_nmi_ff |-> $past(psw_ff[`IAC_PSW_IE_BIT]) && $past(elig_v) != '0)
    else $error("maskable armed while gated");

  a_prio_pick: assert property (
    arm_hit_ff && !arm_nmi_ff |->
      ($past(elig_v) & ((9'h001 << arm_idx_ff) - 9'h001)) == 9'h000)
    else $error("lower priority picked");

  a_hold_instr: assert property (
    state_ff == IAC_IDLE && INSTR_LAST && INSTR_HOLDS |=> !ACK_BUSY)
    else $error("accepted after flag instruction");

  a_hold_access: assert property (
    state_ff == IAC_IDLE && flag_access |=> !ACK_BUSY)
    else $error("accepted during flag access");

  a_flag_clear: assert property (
    $rose(ACK_BUSY) && !sel_nmi_ff |->
      !if_ff[sel_idx_ff] || $past(SRC_REQ[arm_idx_ff]))
    else $error("request flag not cleared");

  a_last_clock: assert property (
    state_ff == IAC_IDLE && INSTR_LAST && !$past(arb_hit) |=> !ACK_BUSY)
    else $error("late request accepted early");

  a_nmi_taken: assert property (
    state_ff == IAC_IDLE && INSTR_LAST && !INSTR_HOLDS && !flag_access
      && $past(nmi_pend_ff) |=> ACK_BUSY && sel_nmi_ff)
    else $error("pending nmi not taken at boundary");

endmodule
`default_nettype wire

// *** tb/iac_cpu_model.sv ***
// cpu sequencer model: fixed length instructions, stalls during acceptance
// assumes the acceptance control on the same clock and reset
`timescale 1ns/1ps
`default_nettype none

module iac_cpu_model #(
  parameter int ILEN = 4
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // acceptance side
  input  wire logic        ack_busy,
  input  wire logic        pc_load,
  input  wire logic [15:0] pc_vector,
  // sequencer outputs
  output logic             instr_last,
  output logic [15:0]      core_pc
);
  logic [3:0]  cnt_ff;
  logic [15:0] pc_ff;

  // instruction clock count, held at zero while acceptance runs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 4'h0;
    end else if (ack_busy || instr_last) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  // program counter, branches on vector load
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pc_ff <= 16'h0100;
    end else if (pc_load) begin
      pc_ff <= pc_vector;
    end else if (instr_last) begin
      pc_ff <= pc_ff + 16'h0002;
    end
  end

  assign instr_last = (cnt_ff == 4'(ILEN - 1)) && !ack_busy;
  assign core_pc    = pc_ff;
endmodule

`default_nettype wire

// *** tb/test_interrupt_acknowledge_control.sv ***
// testbench of the interrupt acknowledge control with a queue model
// assumes the cpu sequencer model beside it
`timescale 1ns/1ps
`default_nettype none
`include "iac_map.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h want %h", $time, (a), (e)); end end

module test_interrupt_acknowledge_control;
  logic              CLOCK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [17:0]       PADDR;
  logic [31:0]       PWDATA, PRDATA, rd;
  iac_pkg::iac_src_t SRC_REQ;
  logic              NMI_REQ, INSTR_LAST, INSTR_HOLDS, EI_EXEC, DI_EXEC, SERVICE_RETURN_INSTR_EXEC, er;
  logic              ACK_BUSY, STACK_WR, STACK_SEL_PC, PC_LOAD, GAE, IRQ;
  logic [7:0]        SERVICE_RETURN_INSTR_PSW, psw_m;
  logic [15:0]       CORE_PC, STACK_DATA, PC_VECTOR, v;
  logic [8:0]        m;
  logic [15:0]       exp_vec[$];
  logic [15:0]       idx_t[7] = '{16'hFFE0, 16'hFFE1, 16'hFFE2, 16'hFFE4, 16'hFFE5,
                                  16'hFFE6, 16'hFFE7};
  logic [7:0]        rst_t[7] = '{8'h00, 8'h00, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'h00};
  integer            miscompares = 0, samples_checked = 0, loads = 0, cyc = 0;
  integer            req_cyc = 0, i, k, seed;

  iac_ctrl i_dut (.CLOCK(CLOCK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA),
    .PSLVERR(PSLVERR), .SRC_REQ(SRC_REQ), .NMI_REQ(NMI_REQ), .INSTR_LAST(INSTR_LAST),
    .INSTR_HOLDS(INSTR_HOLDS), .EI_EXEC(EI_EXEC), .DI_EXEC(DI_EXEC), .SERVICE_RETURN_INSTR_EXEC(SERVICE_RETURN_INSTR_EXEC),
    .SERVICE_RETURN_INSTR_PSW(SERVICE_RETURN_INSTR_PSW), .CORE_PC(CORE_PC), .ACK_BUSY(ACK_BUSY), .STACK_WR(STACK_WR),
    .STACK_SEL_PC(STACK_SEL_PC), .STACK_DATA(STACK_DATA), .PC_LOAD(PC_LOAD),
    .PC_VECTOR(PC_VECTOR), .GLOBAL_ACCEPT_ENABLE(GAE), .IRQ(IRQ));

  iac_cpu_model i_cpu (.clock(CLOCK), .arst_n(ARST_N), .ack_busy(ACK_BUSY),
    .pc_load(PC_LOAD), .pc_vector(PC_VECTOR), .instr_last(INSTR_LAST), .core_pc(CORE_PC));

  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end

  // model side: expected vectors, latency and pushed status word
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (STACK_WR === 1'b1 && STACK_SEL_PC === 1'b0) `CHK(STACK_DATA[7:0], psw_m)
    if (STACK_WR === 1'b1 && STACK_SEL_PC === 1'b1) `CHK(STACK_DATA, CORE_PC)
    if (STACK_WR === 1'b1) `CHK(ACK_BUSY, 1'b1)
    if (PC_LOAD === 1'b1) begin
      loads <= loads + 1;
      v = exp_vec.size() ? exp_vec.pop_front() : 16'hXXXX;
      `CHK(PC_VECTOR, v)
      `CHK(cyc - req_cyc <= `IAC_LAT_MAX_CLK, 1'b1)
      psw_m[7] = 1'b0;
    end
  end

  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic stall;
    miscompares++;
    $display("[FAIL] %0t wait timed out", $time);
    print_verdict;
  endtask

  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    integer n;
    @(posedge CLOCK);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= {idx, 2'b00};
    PWDATA  <= {24'h000000, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) stall();
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rchk(input logic [15:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    `CHK(rd, {24'h000000, e})
  endtask

  task automatic raise(input iac_pkg::iac_src_t s, input logic n);
    @(posedge CLOCK);
    SRC_REQ <= s;
    NMI_REQ <= n;
    req_cyc = cyc;
    @(posedge CLOCK);
    SRC_REQ <= '0;
    NMI_REQ <= 1'b0;
  endtask

  task automatic cmd(input logic e, input logic r);
    @(posedge CLOCK);
    EI_EXEC   <= e;
    SERVICE_RETURN_INSTR_EXEC <= r;
    SERVICE_RETURN_INSTR_PSW  <= 8'h82;
    psw_m = r ? 8'h82 : (psw_m | 8'h80);
    req_cyc = cyc;
    @(posedge CLOCK);
    EI_EXEC   <= 1'b0;
    SERVICE_RETURN_INSTR_EXEC <= 1'b0;
  endtask

  task automatic wait_load;
    integer n, l0;
    n = 0;
    l0 = loads;
    while (loads == l0 && n < 60) begin
      @(posedge CLOCK);
      n++;
    end
    if (n >= 60) stall();
  endtask

  initial begin
    {ARST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, SRC_REQ, NMI_REQ} = '0;
    {INSTR_HOLDS, EI_EXEC, DI_EXEC, SERVICE_RETURN_INSTR_EXEC, SERVICE_RETURN_INSTR_PSW} = '0;
    psw_m = 8'h02;
    seed = $urandom(88063);
    repeat (8) @(posedge CLOCK);
    ARST_N <= 1'b1;
    repeat (3) @(posedge CLOCK);
    // reset values, unmapped place
    for (k = 0; k < 7; k++) rchk(idx_t[k], rst_t[k]);
    apb(1'b0, 16'hFFE3, 8'h00);
    `CHK(er, 1'b1)
    // two sources together, second waits for the return
    apb(1'b1, 16'hFFE7, 8'h03);
    apb(1'b1, 16'hFFE4, 8'hD7);
    apb(1'b1, 16'hFFE2, 8'h82);
    psw_m = 8'h82;
    exp_vec.push_back(`IAC_VEC_BASE + 16'h0006);
    exp_vec.push_back(`IAC_VEC_BASE + 16'h000A);
    raise(9'h028, 1'b0);
    wait_load;
    `CHK(GAE, 1'b0)
    rchk(16'hFFE0, 8'h20);
    rchk(16'hFFE2, 8'h02);
    repeat (10) @(posedge CLOCK);
    `CHK(loads, 1)
    cmd(1'b0, 1'b1);
    wait_load;
    `CHK(IRQ, 1'b1)
    // nmi over maskable, nmi over nmi service
    apb(1'b1, 16'hFFE2, 8'h82);
    psw_m = 8'h82;
    exp_vec.push_back(`IAC_VEC_NMI);
    exp_vec.push_back(`IAC_VEC_NMI);
    exp_vec.push_back(`IAC_VEC_BASE + 16'h0006);
    raise(9'h008, 1'b1);
    wait_load;
    raise(9'h000, 1'b1);
    wait_load;
    cmd(1'b0, 1'b1);
    wait_load;
    // random single sources, every other one under a hold
    for (k = 0; k < 6; k++) begin
      i = $urandom % 9;
      m = ~(9'h001 << i);
      apb(1'b1, 16'hFFE4, {1'b1, m[6:0]});
      apb(1'b1, 16'hFFE5, {m[8], 6'h3F, m[7]});
      cmd(1'b1, 1'b0);
      exp_vec.push_back(`IAC_VEC_BASE + 16'(2 * i));
      INSTR_HOLDS <= k[0];
      raise(9'h001 << i, 1'b0);
      if (k[0]) begin
        repeat (20) @(posedge CLOCK);
        `CHK(exp_vec.size(), 1)
        INSTR_HOLDS <= 1'b0;
        req_cyc = cyc;
      end
      wait_load;
    end
    // disable instruction holds the last source until enable
    cmd(1'b1, 1'b0);
    @(posedge CLOCK);
    DI_EXEC <= 1'b1;
    @(posedge CLOCK);
    DI_EXEC <= 1'b0;
    psw_m[7] = 1'b0;
    exp_vec.push_back(`IAC_VEC_BASE + 16'(2 * i));
    raise(9'h001 << i, 1'b0);
    repeat (20) @(posedge CLOCK);
    `CHK(exp_vec.size(), 1)
    cmd(1'b1, 1'b0);
    wait_load;
    // event status, its mask and clearing
    rchk(16'hFFE6, 8'h03);
    apb(1'b1, 16'hFFE7, 8'h00);
    repeat (2) @(posedge CLOCK);
    `CHK(IRQ, 1'b0)
    apb(1'b1, 16'hFFE7, 8'h03);
    repeat (2) @(posedge CLOCK);
    `CHK(IRQ, 1'b1)
    apb(1'b1, 16'hFFE6, 8'h03);
    repeat (2) @(posedge CLOCK);
    `CHK(IRQ, 1'b0)
    rchk(16'hFFE6, 8'h00);
    print_verdict;
  end
endmodule

`default_nettype wire
